// >>> shared/fwpot_pkg.sv
// constants, types and timing shared by both ends of the flash protection link
package fwpot_pkg;

  // ****************************************
  // clock and documented times
  // ****************************************
  localparam real CLK_PERIOD_NS = 50.0;
  localparam real PROG_MAX_MS = 2.5;
  localparam real ERASE_MAX_MS = 30.0;
  localparam real CHIP_ERASE_MAX_MS = 160.0;
  localparam real SUSPEND_LAT_US = 30.0;
  localparam real RESUME_GAP_MIN_US = 20.0;
  localparam real RESUME_GAP_AVG_US = 100.0;
  localparam real POWER_UP_SELECT_DELAY_US = 150.0;

  // ****************************************
  // cycle counts derived from the times
  // ****************************************
  localparam int PROG_MAX_CYC = $rtoi(PROG_MAX_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int ERASE_MAX_CYC = $rtoi(ERASE_MAX_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int CHIP_ERASE_MAX_CYC = $rtoi(CHIP_ERASE_MAX_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam logic [11:0] SUSPEND_LAT_CYC = 12'($rtoi(SUSPEND_LAT_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int RESUME_GAP_MIN_CYC = $rtoi($ceil(RESUME_GAP_MIN_US * 1.0e3 / CLK_PERIOD_NS));
  // the host waits the average figure, which also covers the least gap
  localparam logic [11:0] PROGRAM_RESUME_TO_SUSPEND_GAP_CYC =
    12'($rtoi($ceil(RESUME_GAP_AVG_US * 1.0e3 / CLK_PERIOD_NS)));
  localparam logic [11:0] ERASE_RESUME_TO_SUSPEND_GAP_CYC = PROGRAM_RESUME_TO_SUSPEND_GAP_CYC;
  localparam logic [11:0] POWER_UP_SELECT_DELAY_CYC =
    12'($rtoi($ceil(POWER_UP_SELECT_DELAY_US * 1.0e3 / CLK_PERIOD_NS)));
  localparam logic [11:0] LINK_HALF_CYC = 12'h008;
  localparam logic [11:0] LINK_DESEL_CYC = 12'h010;
  localparam int TIMER_W = 22;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] OPC_SET_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OPC_SUSPEND = 8'h75;
  localparam logic [7:0] OPC_RESUME = 8'h7a;
  localparam logic [7:0] OPC_DEEP_PD = 8'hb9;
  localparam logic [7:0] OPC_RELEASE_PD = 8'hab;

  // ****************************************
  // frame lengths in bits and array geometry
  // ****************************************
  localparam logic [5:0] FRAME_BITS_OP = 6'h08;
  localparam logic [5:0] FRAME_BITS_STATUS = 6'h18;
  localparam logic [5:0] FRAME_BITS_ADDR = 6'h20;
  localparam logic [5:0] FRAME_BITS_PROG = 6'h28;
  localparam logic [22:0] ARRAY_SIZE = 23'h400000;
  localparam logic [22:0] SIZE_64K = 23'h010000;
  localparam logic [22:0] SIZE_32K = 23'h008000;
  localparam logic [22:0] SIZE_4K = 23'h001000;
  localparam logic [22:0] SIZE_PAGE = 23'h000100;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_RUN = 3'b010,
    OP_SUSP = 3'b100
  } fwpot_op_t;

  typedef enum logic [5:0] {
    H_PWRUP = 6'b000001,
    H_IDLE = 6'b000010,
    H_GAPWAIT = 6'b000100,
    H_SHIFT = 6'b001000,
    H_DESEL = 6'b010000,
    H_SUSPWAIT = 6'b100000
  } fwpot_hstate_t;

endpackage : fwpot_pkg

// >>> shared/fwpot_link_if.sv
// serial link between the flash controller and the flash device
`timescale 1ns/1ps
interface fwpot_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic wp_n;
  modport host (output sclk, output cs_n, output mosi, output wp_n, input miso);
  modport dev (input sclk, input cs_n, input mosi, input wp_n, output miso);
endinterface : fwpot_link_if

// >>> core/fwpot_sync.sv
// two-stage synchroniser for pins from another clock domain
`timescale 1ns/1ps
module fwpot_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // pins
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fwpot_sync_t;

  fwpot_sync_t st;
  fwpot_sync_t next_st;

  always_comb begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    if (srst_in) begin
      next_st.s1 = RST;
      next_st.s2 = RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st <= next_st;
  end

  assign sync_out = st.s2;
endmodule : fwpot_sync

// >>> core/fwpot_device.sv
// flash device end: command intake, write protection and operation timing
// Functional notes
// - host keeps link rate within dummy limits
// - suspend reached within thirty microseconds
// - host waits after program resume before suspend
// - host waits after erase resume before suspend
// - host keeps average resume-to-suspend above 100us
// - page program finishes within 2.5 ms
// - erases finish within 30 ms, chip 160
// - host holds select high until power settles
// - reset returns control to standby
// - status starts at zero, array erased
// - commands must end on byte boundary
// - modifying commands need write enable latch set
// - protect bits select top/bottom 64K blocks
// - zero protects none, seven all, small sizes
// - write-protect pin low freezes protect bits
// - deep power-down ignores all but release
// - program/erase touching protected area is ignored
// - scheme select one uses per-block locks; here it protects the whole array
`timescale 1ns/1ps
module fwpot_device import fwpot_pkg::*; #(
  parameter logic [TIMER_W-1:0] PROG_CYC = TIMER_W'(PROG_MAX_CYC),
  parameter logic [TIMER_W-1:0] ERASE_CYC = TIMER_W'(ERASE_MAX_CYC),
  parameter logic [TIMER_W-1:0] CHIP_ERASE_CYC = TIMER_W'(CHIP_ERASE_MAX_CYC)
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // link
  fwpot_link_if.dev link,
  // user side state
  output logic [7:0] status_out,
  output logic [7:0] config_out,
  output logic busy_out,
  output logic reject_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic sclk_q;
    logic in_frame;
    logic [2:0] bitcnt;
    logic [2:0] bytecnt;
    logic [6:0] shreg;
    logic [7:0] opcode;
    logic [31:0] arg;
    logic [15:0] tx;
    logic miso;
    logic [4:0] bp;
    logic lock0;
    logic lock1;
    logic scheme;
    logic write_enable_latch;
    fwpot_op_t op;
    logic [TIMER_W-1:0] timer;
    logic deep_pd;
    logic reject;
  } fwpot_dev_t;
  fwpot_dev_t st;
  fwpot_dev_t next_st;
  logic [3:0] pins_s;
  logic [7:0] stat_v;
  logic [7:0] conf_v;
  fwpot_sync #(
    .W(4),
    .RST(4'ha)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .async_in({link.wp_n, link.mosi, link.cs_n, link.sclk}),
    .sync_out(pins_s)
  );
  assign stat_v = {st.lock0, st.bp, st.write_enable_latch, st.op[1]};
  assign conf_v = {4'h0, st.deep_pd, st.op[2], st.scheme, st.lock1};
  // ****************************************
  // protected range as [lo, hi)
  // ****************************************
  function automatic logic [45:0] prot_range(input logic [4:0] bp, input logic scheme);
    logic [22:0] sz;
    logic [22:0] lo;
    sz = '0;
    if (scheme || bp[2:0] == 3'h7) begin
      sz = ARRAY_SIZE;
    end else if (bp[2:0] == 3'h0) begin
      sz = '0;
    end else if (!bp[4]) begin
      sz = SIZE_64K << (bp[2:0] - 3'h1);
    end else if (bp[2]) begin
      sz = SIZE_32K;
    end else begin
      sz = SIZE_4K << (bp[2:0] - 3'h1);
    end
    lo = bp[3] ? 23'h000000 : ARRAY_SIZE - sz;
    return {lo, 23'(lo + sz)};
  endfunction : prot_range
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] nbyte;
    logic [7:0] sbyte;
    logic [22:0] tsize;
    logic [22:0] tlo;
    logic [22:0] thi;
    logic [22:0] plo;
    logic [22:0] phi;
    logic [21:0] taddr;
    logic [TIMER_W-1:0] tcyc;
    logic len_ok;
    logic hit;
    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic wp_n_s;
    nbyte = '0;
    sbyte = '0;
    tsize = ARRAY_SIZE;
    tcyc = ERASE_CYC;
    len_ok = st.bytecnt == 3'h4;
    {wp_n_s, mosi_s, cs_n_s, sclk_s} = pins_s;
    next_st = st;
    next_st.reject = 1'b0;
    next_st.sclk_q = sclk_s;
    // running operation counts down to completion
    if (st.op == OP_RUN) begin
      if (st.timer == '0) begin
        next_st.op = OP_IDLE;
      end else begin
        next_st.timer = st.timer - TIMER_W'(1);
      end
    end
    // target range of a modifying command
    case (st.opcode)
      OPC_PAGE_PROG: begin
        tsize = SIZE_PAGE;
        tcyc = PROG_CYC;
        len_ok = st.bytecnt >= 3'h5;
      end
      OPC_SECTOR_ERASE: tsize = SIZE_4K;
      OPC_BLOCK32_ERASE: tsize = SIZE_32K;
      OPC_BLOCK64_ERASE: tsize = SIZE_64K;
      default: begin
        tcyc = CHIP_ERASE_CYC;
        len_ok = st.bytecnt == 3'h1;
      end
    endcase
    taddr = (st.opcode == OPC_PAGE_PROG) ? st.arg[29:8] : st.arg[21:0];
    tlo = {1'b0, taddr} & ~(tsize - 23'h1);
    thi = 23'(tlo + tsize);
    {plo, phi} = prot_range(st.bp, st.scheme);
    hit = (plo != phi) && (tlo < phi) && (thi > plo);
    if (cs_n_s) begin
      next_st.miso = 1'b0;
      if (st.in_frame) begin
        next_st.in_frame = 1'b0;
        if (st.bitcnt != 3'h0) begin
          next_st.reject = 1'b1;
        end else if (st.bytecnt != 3'h0) begin
          if (st.deep_pd) begin
            if (st.opcode == OPC_RELEASE_PD) begin
              next_st.deep_pd = 1'b0;
            end else begin
              next_st.reject = 1'b1;
            end
          end else begin
            case (st.opcode)
              OPC_SET_WRITE_ENABLE: next_st.write_enable_latch = 1'b1;
              OPC_WRITE_DISABLE: next_st.write_enable_latch = 1'b0;
              OPC_READ_STATUS: next_st.write_enable_latch = st.write_enable_latch;
              OPC_WRITE_STATUS: begin
                if (!st.write_enable_latch || st.op != OP_IDLE || st.bytecnt < 3'h2) begin
                  next_st.reject = 1'b1;
                end else begin
                  next_st.write_enable_latch = 1'b0;
                  sbyte = (st.bytecnt == 3'h2) ? st.arg[7:0] : st.arg[15:8];
                  if (wp_n_s) begin
                    next_st.bp = sbyte[6:2];
                    next_st.lock0 = sbyte[7];
                    if (st.bytecnt >= 3'h3) begin
                      next_st.lock1 = st.arg[0];
                    end
                  end
                  if (st.bytecnt >= 3'h3) begin
                    next_st.scheme = st.arg[1];
                  end
                end
              end
              OPC_PAGE_PROG, OPC_SECTOR_ERASE, OPC_BLOCK32_ERASE, OPC_BLOCK64_ERASE,
              OPC_CHIP_ERASE: begin
                if (!st.write_enable_latch || st.op != OP_IDLE || !len_ok || hit) begin
                  next_st.reject = 1'b1;
                end else begin
                  next_st.write_enable_latch = 1'b0;
                  next_st.op = OP_RUN;
                  next_st.timer = tcyc - TIMER_W'(1);
                end
              end
              OPC_SUSPEND: begin
                if (st.op == OP_RUN) begin
                  next_st.op = OP_SUSP;
                end else begin
                  next_st.reject = 1'b1;
                end
              end
              OPC_RESUME: begin
                if (st.op == OP_SUSP) begin
                  next_st.op = OP_RUN;
                end else begin
                  next_st.reject = 1'b1;
                end
              end
              OPC_DEEP_PD: begin
                if (st.op == OP_IDLE) begin
                  next_st.deep_pd = 1'b1;
                end else begin
                  next_st.reject = 1'b1;
                end
              end
              default: next_st.reject = 1'b1;
            endcase
          end
        end
      end
    end else if (!st.in_frame) begin
      next_st.in_frame = 1'b1;
      next_st.bitcnt = 3'h0;
      next_st.bytecnt = 3'h0;
      next_st.arg = '0;
      next_st.tx = '0;
    end else if (sclk_s && !st.sclk_q) begin
      nbyte = {st.shreg, mosi_s};
      next_st.shreg = nbyte[6:0];
      next_st.bitcnt = st.bitcnt + 3'h1;
      if (st.bitcnt == 3'h7) begin
        if (st.bytecnt != 3'h7) begin
          next_st.bytecnt = st.bytecnt + 3'h1;
        end
        if (st.bytecnt == 3'h0) begin
          next_st.opcode = nbyte;
          if (nbyte == OPC_READ_STATUS && !st.deep_pd) begin
            next_st.tx = {stat_v, conf_v};
          end
        end else if (st.bytecnt < 3'h5) begin
          next_st.arg = {st.arg[23:0], nbyte};
        end
      end
    end else if (!sclk_s && st.sclk_q) begin
      next_st.miso = st.tx[15];
      next_st.tx = {st.tx[14:0], 1'b0};
    end
    if (srst_in) begin
      next_st = '0;
      next_st.op = OP_IDLE;
      {next_st.lock0, next_st.bp, next_st.write_enable_latch} = STATUS_RST[7:1];
    end
  end
  always_ff @(posedge core_clk_in) begin
    st <= next_st;
  end
  // ****************************************
  // outputs
  // ****************************************
  assign link.miso = st.miso;
  assign status_out = stat_v;
  assign config_out = conf_v;
  assign busy_out = st.op[1];
  assign reject_out = st.reject;
endmodule : fwpot_device

// >>> core/fwpot_host.sv
// flash controller end: frames commands onto the serial link
`timescale 1ns/1ps
module fwpot_host import fwpot_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // link
  fwpot_link_if.host link,
  // command request
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wp_assert_in,
  // answer
  output logic ready_out,
  output logic done_out,
  output logic [15:0] rdata_out
);

  typedef struct packed {
    fwpot_hstate_t state;
    logic [11:0] cnt;
    logic [11:0] gap;
    logic [39:0] tx;
    logic [5:0] nbits;
    logic [15:0] rx;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic wp_n;
    logic main_pend;
    logic [7:0] op;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic ready;
    logic done;
    logic [15:0] rdata;
  } fwpot_host_t;

  fwpot_host_t st;
  fwpot_host_t next_st;
  logic miso_s;

  fwpot_sync #(
    .W(1),
    .RST(1'h0)
  ) u_sync (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .async_in(link.miso),
    .sync_out(miso_s)
  );

  // ****************************************
  // frame contents
  // ****************************************
  function automatic logic [45:0] frame_of(input logic [7:0] op, input logic [23:0] a,
                                           input logic [15:0] d);
    case (op)
      OPC_READ_STATUS, OPC_WRITE_STATUS: return {FRAME_BITS_STATUS, op, d, 16'h0000};
      OPC_PAGE_PROG: return {FRAME_BITS_PROG, op, a, d[7:0]};
      OPC_SECTOR_ERASE, OPC_BLOCK32_ERASE, OPC_BLOCK64_ERASE:
        return {FRAME_BITS_ADDR, op, a, 8'h00};
      default: return {FRAME_BITS_OP, op, 32'h00000000};
    endcase
  endfunction : frame_of

  function automatic logic is_modify(input logic [7:0] op);
    return op == OPC_WRITE_STATUS || op == OPC_PAGE_PROG || op == OPC_SECTOR_ERASE ||
           op == OPC_BLOCK32_ERASE || op == OPC_BLOCK64_ERASE || op == OPC_CHIP_ERASE;
  endfunction : is_modify

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [45:0] f;
    logic start;
    f = frame_of(st.op, st.addr, st.wdata);
    start = 1'b0;
    next_st = st;
    next_st.done = 1'b0;
    next_st.wp_n = !wp_assert_in;
    if (st.gap != 12'h000) begin
      next_st.gap = st.gap - 12'h001;
    end
    if (st.cnt != 12'h000) begin
      next_st.cnt = st.cnt - 12'h001;
    end

    case (st.state)
      H_PWRUP: begin
        next_st.cs_n = 1'b1;
        if (st.cnt == 12'h000) begin
          next_st.state = H_IDLE;
          next_st.ready = 1'b1;
        end
      end
      H_IDLE: begin
        if (cmd_valid_in) begin
          next_st.ready = 1'b0;
          next_st.op = cmd_in;
          next_st.addr = addr_in;
          next_st.wdata = wdata_in;
          if (cmd_in == OPC_SUSPEND && st.gap != 12'h000) begin
            next_st.state = H_GAPWAIT;
          end else if (is_modify(cmd_in)) begin
            f = frame_of(OPC_SET_WRITE_ENABLE, addr_in, wdata_in);
            next_st.main_pend = 1'b1;
            start = 1'b1;
          end else begin
            f = frame_of(cmd_in, addr_in, wdata_in);
            start = 1'b1;
          end
        end
      end
      H_GAPWAIT: begin
        if (st.gap == 12'h000) begin
          start = 1'b1;
        end
      end
      H_SHIFT: begin
        if (st.cnt == 12'h000) begin
          next_st.cnt = LINK_HALF_CYC - 12'h001;
          if (!st.sclk) begin
            if (st.nbits == 6'h00) begin
              next_st.cs_n = 1'b1;
              next_st.cnt = LINK_DESEL_CYC;
              next_st.state = H_DESEL;
            end else begin
              next_st.sclk = 1'b1;
              next_st.rx = {st.rx[14:0], miso_s};
            end
          end else begin
            next_st.sclk = 1'b0;
            next_st.tx = {st.tx[38:0], 1'b0};
            next_st.mosi = st.tx[38];
            next_st.nbits = st.nbits - 6'h01;
          end
        end
      end
      H_DESEL: begin
        if (st.cnt == 12'h000) begin
          if (st.main_pend) begin
            next_st.main_pend = 1'b0;
            start = 1'b1;
          end else if (st.op == OPC_SUSPEND) begin
            next_st.cnt = SUSPEND_LAT_CYC;
            next_st.state = H_SUSPWAIT;
          end else begin
            next_st.done = 1'b1;
            next_st.ready = 1'b1;
            next_st.rdata = st.rx;
            next_st.state = H_IDLE;
            if (st.op == OPC_RESUME) begin
              next_st.gap = PROGRAM_RESUME_TO_SUSPEND_GAP_CYC;
            end
          end
        end
      end
      H_SUSPWAIT: begin
        if (st.cnt == 12'h000) begin
          next_st.done = 1'b1;
          next_st.ready = 1'b1;
          next_st.rdata = st.rx;
          next_st.state = H_IDLE;
        end
      end
      default: next_st.state = H_IDLE;
    endcase

    if (start) begin
      next_st.cs_n = 1'b0;
      next_st.sclk = 1'b0;
      next_st.nbits = f[45:40];
      next_st.tx = f[39:0];
      next_st.mosi = f[39];
      next_st.rx = '0;
      next_st.cnt = LINK_HALF_CYC - 12'h001;
      next_st.state = H_SHIFT;
    end

    if (srst_in) begin
      next_st = '0;
      next_st.state = H_PWRUP;
      next_st.cnt = POWER_UP_SELECT_DELAY_CYC;
      next_st.cs_n = 1'b1;
      next_st.wp_n = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st <= next_st;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.sclk = st.sclk;
  assign link.cs_n = st.cs_n;
  assign link.mosi = st.mosi;
  assign link.wp_n = st.wp_n;
  assign ready_out = st.ready;
  assign done_out = st.done;
  assign rdata_out = st.rdata;

endmodule : fwpot_host

// >>> tb/fwpot_asserts.sv
// link protocol checks between the flash controller and flash device ends
`timescale 1ns/1ps
module fwpot_asserts import fwpot_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic wp_n
);
  // ****************************************
  // helper counters
  // ****************************************
  logic [11:0] pu_cnt;
  logic [5:0] rise_cnt;
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pu_cnt <= 12'h000;
      rise_cnt <= 6'h00;
    end else begin
      if (pu_cnt != 12'hfff) pu_cnt <= pu_cnt + 12'h001;
      if ($fell(cs_n)) rise_cnt <= 6'h00;
      else if ($rose(sclk)) rise_cnt <= rise_cnt + 6'h01;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  power_up_quiet_a: assert property (pu_cnt < POWER_UP_SELECT_DELAY_CYC |-> cs_n)
    else $error("select driven during power-up delay");
  byte_frame_a: assert property ($rose(cs_n) |-> rise_cnt[2:0] == 3'h0)
    else $error("frame not whole bytes");
  idle_clock_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  high_half_a: assert property ($rose(sclk) |=> sclk [*7])
    else $error("serial clock high half too short");
  low_half_a: assert property ($fell(sclk) |=> !sclk [*7])
    else $error("serial clock low half too short");
  mosi_hold_a: assert property ($rose(sclk) |=> $stable(mosi) [*7])
    else $error("host data moved while clock high");
  desel_gap_a: assert property ($rose(cs_n) |=> cs_n [*3])
    else $error("deselect gap too short");
  miso_idle_a: assert property (cs_n [*8] |-> !miso)
    else $error("device data not idle outside frame");
  cover property ($rose(cs_n) && !wp_n);
endmodule : fwpot_asserts

// >>> tb/fwpot_bench.sv
// self-checking bench joining the flash controller and flash device ends
`timescale 1ns/1ps
module fwpot_bench import fwpot_pkg::*; ;
  localparam int PROG_N = 40;
  localparam int ERASE_N = 400;
  localparam int CHIP_N = 500;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic cmd_valid_in = 1'b0;
  logic [7:0] cmd_in = 8'h00;
  logic [23:0] addr_in = 24'h000000;
  logic [15:0] wdata_in = 16'h0000;
  logic wp_assert_in = 1'b0;
  logic ready_out, done_out, busy_out, reject_out;
  logic [15:0] rdata_out;
  logic [7:0] status_out, config_out;
  int errors = 0;
  int n_tests = 0;
  int busy_cnt = 0;
  int rej_seen = 0;
  // protect byte, opcode, target, refused
  logic [40:0] rows [13] = '{{8'h04, 8'hd8, 24'h3f0000, 1'b1}, {8'h04, 8'h20, 24'h3ef000, 1'b0},
    {8'h24, 8'h02, 24'h000100, 1'b1}, {8'h24, 8'h20, 24'h010000, 1'b0},
    {8'h18, 8'h20, 24'h200000, 1'b1}, {8'h18, 8'h20, 24'h1ff000, 1'b0},
    {8'h44, 8'h20, 24'h3ff000, 1'b1}, {8'h44, 8'h02, 24'h3fef00, 1'b0},
    {8'h58, 8'h52, 24'h3f8000, 1'b1}, {8'h58, 8'h52, 24'h3f0000, 1'b0},
    {8'h64, 8'h20, 24'h000000, 1'b1}, {8'h1c, 8'h20, 24'h000000, 1'b1},
    {8'h00, 8'hc7, 24'h000000, 1'b0}};
  fwpot_link_if link ();
  fwpot_host fwpot_host_i (.core_clk_in(core_clk_in), .srst_in(srst_in), .link(link.host),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wp_assert_in(wp_assert_in), .ready_out(ready_out), .done_out(done_out),
    .rdata_out(rdata_out));
  fwpot_device #(.PROG_CYC(TIMER_W'(PROG_N)), .ERASE_CYC(TIMER_W'(ERASE_N)),
    .CHIP_ERASE_CYC(TIMER_W'(CHIP_N))) fwpot_device_i (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .link(link.dev), .status_out(status_out), .config_out(config_out),
    .busy_out(busy_out), .reject_out(reject_out));
  fwpot_asserts fwpot_asserts_i (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .wp_n(link.wp_n));
  always #25 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    if (busy_out === 1'b1) busy_cnt <= busy_cnt + 1;
    if (reject_out === 1'b1) rej_seen <= 1;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic hang(input int k, input int lim);
    if (k >= lim) begin
      errors++;
      final_report();
    end
  endtask : hang
  task automatic send(input logic [7:0] op, input logic [23:0] a, input logic [15:0] d);
    int k;
    k = 0;
    while (ready_out !== 1'b1 && k < 9000) begin
      @(negedge core_clk_in);
      k++;
    end
    cmd_in = op;
    addr_in = a;
    wdata_in = d;
    cmd_valid_in = 1'b1;
    rej_seen = 0;
    @(negedge core_clk_in);
    cmd_valid_in = 1'b0;
    while (done_out !== 1'b1 && k < 9000) begin
      @(negedge core_clk_in);
      k++;
    end
    hang(k, 9000);
  endtask : send
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy_out !== 1'b0 && k < 2000) begin
      @(negedge core_clk_in);
      k++;
    end
    hang(k, 2000);
  endtask : wait_idle
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check("status at reset", 16'h0000, {8'h00, status_out});
    check("config and busy at reset", 16'h0000, {config_out, 7'h00, busy_out});
    $display("reset test done");
  endtask : t_reset
  task automatic t_wel();
    send(OPC_SET_WRITE_ENABLE, 24'h000000, 16'h0000);
    check("latch set", 16'h0002, {8'h00, status_out});
    send(OPC_WRITE_DISABLE, 24'h000000, 16'h0000);
    check("latch clear", 16'h0000, {8'h00, status_out});
    $display("write enable test done");
  endtask : t_wel
  task automatic t_prot();
    logic [40:0] r;
    int e;
    for (int i = 0; i < 13; i++) begin
      r = rows[i];
      send(OPC_WRITE_STATUS, 24'h000000, {r[40:33], 8'h00});
      check("protect bits", {8'h00, r[40:33]}, {8'h00, status_out});
      busy_cnt = 0;
      send(r[32:25], r[24:1], 16'h00a5);
      wait_idle();
      check("refused", {15'h0000, r[0]}, 16'(rej_seen));
      e = (r[32:25] == OPC_PAGE_PROG) ? PROG_N : (r[32:25] == OPC_CHIP_ERASE) ? CHIP_N : ERASE_N;
      if (r[0]) e = 0;
      if (busy_cnt < e - 1 || busy_cnt > e + 1) begin
        check("busy cycles", 16'(e), 16'(busy_cnt));
      end else begin
        n_tests++;
      end
    end
    $display("protection test done");
  endtask : t_prot
  task automatic t_wp();
    send(OPC_WRITE_STATUS, 24'h000000, 16'h0400);
    wp_assert_in = 1'b1;
    send(OPC_WRITE_STATUS, 24'h000000, 16'h1800);
    check("frozen protect bits", 16'h0004, {8'h00, status_out});
    send(OPC_READ_STATUS, 24'h000000, 16'h0000);
    check("read status", 16'h0400, rdata_out);
    wp_assert_in = 1'b0;
    send(OPC_WRITE_STATUS, 24'h000000, 16'h0000);
    check("protect bits free", 16'h0000, {8'h00, status_out});
    $display("write protect pin test done");
  endtask : t_wp
  task automatic t_susp();
    busy_cnt = 0;
    send(OPC_SECTOR_ERASE, 24'h000000, 16'h0000);
    send(OPC_SUSPEND, 24'h000000, 16'h0000);
    check("suspended, not busy", 16'h0002, {14'h0000, config_out[2], busy_out});
    send(OPC_RESUME, 24'h000000, 16'h0000);
    check("resumed, busy", 16'h0001, {14'h0000, config_out[2], busy_out});
    wait_idle();
    if (busy_cnt < ERASE_N - 2 || busy_cnt > ERASE_N + 2) begin
      check("erase cycles", 16'(ERASE_N), 16'(busy_cnt));
    end else begin
      n_tests++;
    end
    $display("suspend test done");
  endtask : t_susp
  task automatic t_dpd();
    send(OPC_DEEP_PD, 24'h000000, 16'h0000);
    check("deep power-down", 16'h0008, {8'h00, config_out});
    send(OPC_SET_WRITE_ENABLE, 24'h000000, 16'h0000);
    check("ignored in power-down", 16'h0001, {status_out, 7'h00, rej_seen[0]});
    send(OPC_RELEASE_PD, 24'h000000, 16'h0000);
    check("released", 16'h0000, {8'h00, config_out});
    $display("deep power-down test done");
  endtask : t_dpd
  initial begin
    repeat (5) @(negedge core_clk_in);
    srst_in = 1'b0;
    @(negedge core_clk_in);
    t_reset();
    t_wel();
    t_prot();
    t_wp();
    t_susp();
    t_dpd();
    final_report();
  end
endmodule : fwpot_bench
